// >>> verilog/dbcf_consts.svh
// constants of the dual-bank coefficient filter
`ifndef DBCF_CONSTS_SVH
`define DBCF_CONSTS_SVH

// ********************
// sizes
// ********************
`define DBCF_TAPS 32
`define DBCF_COEF_W 16
`define DBCF_SAMPLE_W 16
`define DBCF_ACC_W 37
`define DBCF_FIFO_DEPTH 16

// ********************
// reset values
// ********************
`define DBCF_BANK_RESET 1'b0
`define DBCF_PEND_RESET 1'b0

`endif

// >>> verilog/dbcf_pkg.sv
// types shared by the dual-bank coefficient filter
`default_nettype none
`include "dbcf_consts.svh"

package dbcf_pkg;
  typedef logic [`DBCF_COEF_W-1:0] dbcf_coef_t;
  typedef logic [`DBCF_SAMPLE_W-1:0] dbcf_sample_t;
  typedef logic [`DBCF_ACC_W-1:0] dbcf_acc_t;
  typedef logic dbcf_bank_t;
endpackage

`default_nettype wire

// >>> verilog/dbcf_fifo.sv
// sample FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module dbcf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clock, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic [WIDTH-1:0] inData, // word to store
  input wire logic inValid, // inData is offered
  output logic inReady, // room for a word
  output logic [WIDTH-1:0] outData, // oldest word
  output logic outValid, // outData holds a word
  input wire logic outReady // drain side takes outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic inReady;
    logic outValid;
  } dbcf_fifo_state_s;

  dbcf_fifo_state_s state_reg;
  dbcf_fifo_state_s state_next;
  logic push;
  logic pop;

  // ********************
  // next state
  // ********************
  always_comb begin
    state_next = state_reg;
    push = inValid && state_reg.inReady;
    pop = state_reg.outValid && outReady;
    if (push) begin
      state_next.mem[state_reg.wr] = inData;
      state_next.wr = (state_reg.wr == AW'(DEPTH - 1)) ? '0 : state_reg.wr + 1'b1;
    end
    if (pop) begin
      state_next.rd = (state_reg.rd == AW'(DEPTH - 1)) ? '0 : state_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 1'b1;
    end
    state_next.inReady = state_next.count != (AW+1)'(DEPTH);
    state_next.outValid = state_next.count != '0;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.inReady <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign inReady = state_reg.inReady;
  assign outValid = state_reg.outValid;
  assign outData = state_reg.mem[state_reg.rd];

endmodule // dbcf_fifo

`default_nettype wire

// >>> verilog/dbcf_filter.sv
// dual-bank coefficient transversal filter with host coefficient port
`timescale 1ns/10ps
`default_nettype none
`include "dbcf_consts.svh"


module dbcf_filter
  import dbcf_pkg::*;
#(
  parameter int TAPS = `DBCF_TAPS,
  parameter int FIFO_DEPTH = `DBCF_FIFO_DEPTH
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire dbcf_sample_t sampleIn, // input sample word
  input wire logic sampleValid, // sampleIn is offered
  output logic sampleReady, // FIFO has room
  input wire logic coefWe, // write strobe to the host-side bank
  input wire logic coefRe, // read strobe from the host-side bank
  input wire logic [4:0] coefAddr, // coefficient index
  input wire dbcf_coef_t coefWrData, // coefficient to write
  output dbcf_coef_t coefRdData, // coefficient read back
  input wire logic swapReq, // pulse: set the one-shot swap bit
  input wire logic contSwap, // level: continuous-swap mode
  output logic swapPending, // one-shot swap bit
  output logic activeBank, // bank used by the next cycle without swap
  output dbcf_acc_t outSample, // filter result
  output logic outValid, // outSample holds a result
  input wire logic outReady // consumer takes outSample
);

  typedef struct packed {
    logic [1:0][TAPS-1:0][`DBCF_COEF_W-1:0] coef;
    logic [TAPS-2:0][`DBCF_ACC_W-1:0] acc;
    dbcf_coef_t rdData;
    logic pending;
    logic bank;
    dbcf_acc_t outSample;
    logic outValid;
    logic lastBank;
    logic lastCont;
  } dbcf_state_s;

  dbcf_state_s state_reg;
  dbcf_state_s state_next;
  dbcf_sample_t fifoData;
  logic fifoValid;
  logic accept;
  logic useBank;
  logic [TAPS-1:0][`DBCF_ACC_W-1:0] prodExt;
  logic [TAPS-2:0][`DBCF_ACC_W-1:0] accNew;

  // ********************
  // sample buffer
  // ********************
  dbcf_fifo #(
    .WIDTH(`DBCF_SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) sampleFifo (
    .clock(clock),
    .reset(reset),
    .inData(sampleIn),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(accept)
  );

  // a new computation cycle starts whenever a sample leaves the FIFO
  assign accept = fifoValid && (!state_reg.outValid || outReady);
  // a pending one-shot swap takes effect at this cycle boundary
  assign useBank = state_reg.bank ^ state_reg.pending;

  // ********************
  // multiply-accumulate array
  // ********************
  genvar k;
  generate
    for (k = 0; k < TAPS; k++) begin : gMac
      logic signed [2*`DBCF_COEF_W-1:0] prod;
      assign prod = $signed(fifoData) * $signed(state_reg.coef[useBank][k]);
      assign prodExt[k] = `DBCF_ACC_W'(prod);
      if (k == TAPS - 2) begin : gLast
        // the far end of the chain has no partial sum behind it
        assign accNew[k] = prodExt[k+1];
      end else if (k < TAPS - 2) begin : gMid
        assign accNew[k] = state_reg.acc[k+1] + prodExt[k+1];
      end
    end
  endgenerate

  // ********************
  // next state
  // ********************
  always_comb begin
    state_next = state_reg;
    // host side targets the bank opposite activeBank; while a one-shot swap is pending that is the bank about to feed the array
    if (coefWe) begin
      state_next.coef[~state_reg.bank][coefAddr] = coefWrData;
    end
    if (coefRe) begin
      state_next.rdData = state_reg.coef[~state_reg.bank][coefAddr];
    end
    if (outReady) begin
      state_next.outValid = 1'b0;
    end
    if (accept) begin
      state_next.outSample = state_reg.acc[0] + prodExt[0];
      state_next.outValid = 1'b1;
      state_next.acc = accNew;
      state_next.bank = useBank ^ contSwap;
      state_next.pending = 1'b0;
      state_next.lastBank = useBank;
      state_next.lastCont = contSwap;
    end
    // a request in the swap cycle itself survives for the next boundary
    if (swapReq) begin
      state_next.pending = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.bank <= `DBCF_BANK_RESET;
      state_reg.pending <= `DBCF_PEND_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign coefRdData = state_reg.rdData;
  assign swapPending = state_reg.pending;
  assign activeBank = state_reg.bank;
  assign outSample = state_reg.outSample;
  assign outValid = state_reg.outValid;

  // ********************
  // checks
  // ********************
  a_reset_state: assert property (@(posedge clock) disable iff (reset)
    $fell(reset) |-> !swapPending && activeBank == `DBCF_BANK_RESET)
    else $error("state after reset wrong");

  a_host_write: assert property (@(posedge clock) disable iff (reset)
    coefWe |=> state_reg.coef[~$past(activeBank)][$past(coefAddr)] == $past(coefWrData))
    else $error("host write missed the idle bank");

  a_host_read: assert property (@(posedge clock) disable iff (reset)
    coefRe && !coefWe |=> coefRdData == state_reg.coef[~$past(activeBank)][$past(coefAddr)])
    else $error("host read wrong word");

  a_oneshot_swap: assert property (@(posedge clock) disable iff (reset)
    accept && swapPending && !contSwap |=> activeBank != $past(activeBank))
    else $error("one-shot swap not taken");

  a_oneshot_clear: assert property (@(posedge clock) disable iff (reset)
    accept && swapPending && !swapReq |=> !swapPending)
    else $error("swap bit not cleared");

  a_no_swap: assert property (@(posedge clock) disable iff (reset)
    !swapPending && !contSwap |=> $stable(activeBank))
    else $error("bank changed without request");

  a_cont_toggle: assert property (@(posedge clock) disable iff (reset)
    accept && contSwap && !swapPending |=> activeBank != $past(activeBank))
    else $error("continuous swap missed");

  a_cont_opposite: assert property (@(posedge clock) disable iff (reset)
    accept && contSwap && state_reg.lastCont && !swapPending |-> useBank != state_reg.lastBank)
    else $error("consecutive samples used same bank");

  a_mac_output: assert property (@(posedge clock) disable iff (reset)
    accept |=> outValid && outSample == $past(state_reg.acc[0] + prodExt[0]))
    else $error("filter output wrong");

  // ********************
  // holding and boundary checks
  // ********************
  a_set_wins: assert property (@(posedge clock) disable iff (reset)
    swapReq |=> swapPending)
    else $error("swap request lost");

  a_pending_held: assert property (@(posedge clock) disable iff (reset)
    swapPending && !accept |=> swapPending)
    else $error("swap bit dropped before use");

  a_swap_new_bank: assert property (@(posedge clock) disable iff (reset)
    accept && swapPending |-> useBank != activeBank)
    else $error("pending swap not applied to sample");

  a_bank_at_boundary: assert property (@(posedge clock) disable iff (reset)
    !accept |=> $stable(activeBank))
    else $error("bank changed between cycles");

  a_cont_next_bank: assert property (@(posedge clock) disable iff (reset)
    accept && contSwap |=> activeBank != $past(useBank))
    else $error("next sample would reuse bank");

  a_active_untouched: assert property (@(posedge clock) disable iff (reset)
    coefWe && !accept |=> $stable(state_reg.coef[activeBank]))
    else $error("host write reached active bank");

  a_read_hold: assert property (@(posedge clock) disable iff (reset)
    !coefRe |=> $stable(coefRdData))
    else $error("read data changed without read");

  a_out_hold: assert property (@(posedge clock) disable iff (reset)
    outValid && !outReady |=> outValid && $stable(outSample))
    else $error("result not held under back-pressure");

endmodule // dbcf_filter

`default_nettype wire

// >>> verilog/dbcf_filter_unused_guard.sv
// nettype guard only; this file holds no logic
`default_nettype none
`default_nettype wire

// >>> tb/dbcf_host_model.sv
// host model: coefficient port, swap pulse and sample stream
`timescale 1ns/10ps
`default_nettype none

module dbcf_host_model
  import dbcf_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sampleReady, // filter has room
  input wire dbcf_coef_t coefRdData, // read data
  output dbcf_sample_t sampleIn, // sample word
  output logic sampleValid, // sample offered
  output logic coefWe, // write strobe
  output logic coefRe, // read strobe
  output logic [4:0] coefAddr, // coefficient index
  output dbcf_coef_t coefWrData, // write data
  output logic swapReq // one-shot swap pulse
);
  initial begin
    sampleIn = 16'h0000;
    sampleValid = 1'b0;
    coefWe = 1'b0;
    coefRe = 1'b0;
    coefAddr = 5'h00;
    coefWrData = 16'h0000;
    swapReq = 1'b0;
  end

  // ********************
  // host transfers
  // ********************
  task automatic putSample(input dbcf_sample_t x);
    @(posedge clock);
    #1 sampleIn = x;
    sampleValid = 1'b1;
    while (sampleReady !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1 sampleValid = 1'b0;
    sampleIn = ~x;
  endtask

  // zero words clear stale partial sums
  task automatic floodZeros(output int taken);
    taken = 0;
    @(posedge clock);
    #1 sampleIn = 16'h0000;
    sampleValid = 1'b1;
    repeat (40) begin
      if (sampleReady === 1'b1) taken++;
      @(posedge clock);
      #1;
    end
    sampleValid = 1'b0;
    sampleIn = 16'hFFFF;
  endtask

  task automatic wrCoef(input logic [4:0] a, input dbcf_coef_t d);
    @(posedge clock);
    #1 coefWe = 1'b1;
    coefAddr = a;
    coefWrData = d;
    @(posedge clock);
    #1 coefWe = 1'b0;
    coefAddr = ~a;
    coefWrData = ~d;
  endtask

  task automatic rdCoef(input logic [4:0] a, output dbcf_coef_t d);
    @(posedge clock);
    #1 coefRe = 1'b1;
    coefAddr = a;
    @(posedge clock);
    #1 coefRe = 1'b0;
    coefAddr = ~a;
    d = coefRdData;
  endtask

  task automatic pulseSwap();
    @(posedge clock);
    #1 swapReq = 1'b1;
    @(posedge clock);
    #1 swapReq = 1'b0;
  endtask
endmodule // dbcf_host_model

`default_nettype wire

// >>> tb/dbcf_filter_tb.sv
// self-checking bench of the dual-bank coefficient filter
`timescale 1ns/10ps
`default_nettype none

module dbcf_filter_tb;
  import dbcf_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic contSwap = 1'b0;
  logic outReady = 1'b0;
  dbcf_sample_t sampleIn;
  logic sampleValid, sampleReady, coefWe, coefRe, swapReq, swapPending, activeBank, outValid;
  logic [4:0] coefAddr;
  dbcf_coef_t coefWrData, coefRdData, rd;
  dbcf_acc_t outSample, v;
  int failCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int n;

  dbcf_filter uut (.clock, .reset, .sampleIn, .sampleValid, .sampleReady, .coefWe, .coefRe,
    .coefAddr, .coefWrData, .coefRdData, .swapReq, .contSwap, .swapPending, .activeBank,
    .outSample, .outValid, .outReady);
  dbcf_host_model host (.clock, .sampleReady, .coefRdData, .sampleIn, .sampleValid, .coefWe,
    .coefRe, .coefAddr, .coefWrData, .swapReq);

  always #12.5 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      tally_and_finish();
    end
  end

  // ********************
  // helpers
  // ********************
  task automatic chk(input string name, input logic [36:0] exp, input logic [36:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic getOut(output dbcf_acc_t r);
    @(posedge clock);
    #1 outReady = 1'b1;
    while (outValid !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    r = outSample;
    @(posedge clock);
    #1 outReady = 1'b0;
  endtask

  task automatic tally_and_finish();
    if (failCount == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic tReset();
    chk("swapPending", 0, swapPending);
    chk("activeBank", 0, activeBank);
    chk("outValid", 0, outValid);
  endtask

  // idle bank is bank 1; both ends of the index range
  task automatic tCoef();
    host.wrCoef(5'h00, 16'h0003);
    host.wrCoef(5'h1F, 16'h7FFF);
    host.rdCoef(5'h1F, rd);
    chk("coef31", 37'h7FFF, rd);
    host.wrCoef(5'h1F, 16'h0000);
    host.rdCoef(5'h00, rd);
    chk("coef0", 37'h3, rd);
  endtask

  task automatic tSwap();
    host.pulseSwap();
    chk("swapPending", 1, swapPending);
    host.putSample(16'h0002);
    getOut(v);
    chk("outSample", 37'h6, v);
    chk("swapPending", 0, swapPending);
    chk("activeBank", 1, activeBank);
    host.putSample(16'h0004);
    getOut(v);
    chk("outSample", 37'hC, v);
    host.rdCoef(5'h00, rd);
    chk("coefIdle", 37'h0, rd);
  endtask

  task automatic tCont();
    host.wrCoef(5'h00, 16'h0005);
    contSwap = 1'b1;
    host.putSample(16'h0002);
    host.putSample(16'h0003);
    host.putSample(16'h0004);
    getOut(v);
    chk("outSample", 37'h6, v);
    getOut(v);
    chk("outSample", 37'hF, v);
    getOut(v);
    chk("outSample", 37'hC, v);
    chk("activeBank", 0, activeBank);
    contSwap = 1'b0;
  endtask

  // consumer stalls until the buffer refuses, then drains slowly
  task automatic tFill();
    host.floodZeros(n);
    chk("sampleReady", 0, sampleReady);
    chk("accepted", 37'd17, n);
    for (int i = 0; i < n; i++) begin
      getOut(v);
      chk("outSample", 37'h0, v);
      repeat (2) @(posedge clock);
    end
    #1;
    chk("outValid", 0, outValid);
    chk("sampleReady", 1, sampleReady);
  endtask

  // impulse walks the chain: output m carries coefficient m
  task automatic tTaps();
    host.wrCoef(5'h01, 16'hFFF9);
    host.wrCoef(5'h1F, 16'h0009);
    host.pulseSwap();
    host.putSample(16'h0002);
    getOut(v);
    chk("tap0", 37'h6, v);
    host.putSample(16'h0000);
    getOut(v);
    chk("tap1", 37'h1FFFFFFFF2, v);
    for (int i = 2; i < 31; i++) begin
      host.putSample(16'h0000);
      getOut(v);
      chk("tapMid", 37'h0, v);
    end
    host.putSample(16'h0000);
    getOut(v);
    chk("tap31", 37'h12, v);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    #1 reset = 1'b0;
    tReset();
    tCoef();
    tSwap();
    tCont();
    tFill();
    tTaps();
    tally_and_finish();
  end
endmodule // dbcf_filter_tb

`default_nettype wire
